// ---- verilog/prom_program_sequencer.sv ----
/*
   PROM programming sequencer: three pushbuttons start blank check, write with
   blank check and verify, compare, and PROM-to-RAM transfer with compare;
   lamps follow each step, status and interrupts are reached over APB.
   Assumes an asynchronous PROM with read strobe and program pulse, and a user
   RAM whose read data is valid a few cycles after its address.
*/
// Operation
// - blank button checks PROM fully erased
// - blank failure keeps blank lamp, lights error
// - write button: blank check, program, verify
// - lamps step blank, write, compare, off
// - verify mismatch keeps compare lamp, lights error
// - compare button compares PROM against RAM
// - error lamp lights on any failed step
// - error button clears error and compare lamps
// - write plus compare copies PROM into RAM
// - after copy, compare with write lamp dark
// - copy compare mismatch lights error lamp
// - fault lamp mirrors controller fault indicator
// - power lamp shows supply present and good
`timescale 1ns/100ps
module prom_program_sequencer #(
   parameter logic [prom_seq_pkg::TMR_W-1:0] PULSE_CYC = 20'(prom_seq_pkg::PULSE_CYC_DEF),
   parameter logic [prom_seq_pkg::TMR_W-1:0] CHORD_CYC = 20'(prom_seq_pkg::CHORD_CYC_DEF)
) (
   input  wire logic                              clk_sys_i,
   input  wire logic                              arst_n_i,
   input  wire logic                              psel_i,
   input  wire logic                              penable_i,
   input  wire logic                              pwrite_i,
   input  wire logic [prom_seq_pkg::APB_AW-1:0]   paddr_i,
   input  wire logic [31:0]                       pwdata_i,
   output logic      [31:0]                       prdata_o,
   output logic                                   pready_o,
   output logic                                   pslverr_o,
   output logic                                   irq_o,
   input  wire logic                              blank_button_i,
   input  wire logic                              write_button_i,
   input  wire logic                              compare_button_i,
   input  wire logic                              error_button_i,
   input  wire logic                              cpu_fault_i,
   input  wire logic                              supply_ok_i,
   output logic                                   blank_lamp_o,
   output logic                                   write_lamp_o,
   output logic                                   compare_button_lamp_o,
   output logic                                   error_lamp_o,
   output logic                                   cpu_fault_lamp_o,
   output logic                                   power_lamp_o,
   output logic      [prom_seq_pkg::ADDR_W-1:0]   prom_addr_o,
   input  wire logic [prom_seq_pkg::DATA_W-1:0]   prom_data_i,
   output logic      [prom_seq_pkg::DATA_W-1:0]   prom_data_o,
   output logic                                   prom_data_oe_o,
   output logic                                   prom_read_n_o,
   output logic                                   prom_prog_o,
   output logic      [prom_seq_pkg::ADDR_W-1:0]   ram_addr_o,
   input  wire logic [prom_seq_pkg::DATA_W-1:0]   ram_rdata_i,
   output logic      [prom_seq_pkg::DATA_W-1:0]   ram_wdata_o,
   output logic                                   ram_we_o
);

   prom_seq_pkg::state_t                    state_reg;
   prom_seq_pkg::phase_t                    phase_reg;
   logic [prom_seq_pkg::ADDR_W-1:0]         addr_reg;
   logic [prom_seq_pkg::ADDR_W-1:0]         last_reg;
   logic [prom_seq_pkg::ADDR_W-1:0]         fail_reg;
   logic                                    wr_seq_reg;
   logic                                    err_blank_reg;
   logic                                    wr_seen_reg;
   logic                                    cmp_seen_reg;
   logic                                    tmr_start_reg;
   logic [prom_seq_pkg::TMR_W-1:0]          tmr_load_reg;
   logic                                    tmr_done;
   logic                                    ev_done_reg;
   logic                                    ev_err_reg;
   logic                                    fault_seen_reg;
   logic [prom_seq_pkg::NUM_EV-1:0]         int_stat_reg;
   logic [prom_seq_pkg::NUM_EV-1:0]         int_en_reg;
   logic [prom_seq_pkg::NUM_EV-1:0]         int_clr;
   logic [prom_seq_pkg::NUM_EV-1:0]         ev_vec;
   logic                                    apb_wr;
   logic [31:0]                             rd_data;
   logic                                    rd_hit;
   logic                                    blank_lvl;
   logic                                    blank_press;
   logic                                    wr_lvl;
   logic                                    wr_press;
   logic                                    cmp_lvl;
   logic                                    cmp_press;
   logic                                    err_lvl;
   logic                                    err_press;
   logic                                    scan_mismatch;
   logic                                    scan_last;

   press_detect u_blank (
      .clk_sys_i (clk_sys_i),
      .arst_n_i  (arst_n_i),
      .btn_i     (blank_button_i),
      .level_o   (blank_lvl),
      .press_o   (blank_press)
   );

   press_detect u_write (
      .clk_sys_i (clk_sys_i),
      .arst_n_i  (arst_n_i),
      .btn_i     (write_button_i),
      .level_o   (wr_lvl),
      .press_o   (wr_press)
   );

   press_detect u_compare (
      .clk_sys_i (clk_sys_i),
      .arst_n_i  (arst_n_i),
      .btn_i     (compare_button_i),
      .level_o   (cmp_lvl),
      .press_o   (cmp_press)
   );

   press_detect u_error (
      .clk_sys_i (clk_sys_i),
      .arst_n_i  (arst_n_i),
      .btn_i     (error_button_i),
      .level_o   (err_lvl),
      .press_o   (err_press)
   );

   step_timer #(
      .W (prom_seq_pkg::TMR_W)
   ) u_timer (
      .clk_sys_i (clk_sys_i),
      .arst_n_i  (arst_n_i),
      .start_i   (tmr_start_reg),
      .load_i    (tmr_load_reg),
      .done_o    (tmr_done)
   );

   // blank check compares against erased value, all others PROM against RAM
   assign scan_mismatch = (state_reg == prom_seq_pkg::S_BLANK) ? (prom_data_i != prom_seq_pkg::BLANK_VALUE)
                                                               : (prom_data_i != ram_rdata_i);
   assign scan_last     = (addr_reg == last_reg);

   // sequencer: one pass over the address range per step
   always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         state_reg      <= prom_seq_pkg::S_IDLE;
         phase_reg      <= prom_seq_pkg::P_ADDR;
         addr_reg       <= '0;
         fail_reg       <= '0;
         wr_seq_reg     <= 1'b0;
         err_blank_reg  <= 1'b0;
         wr_seen_reg    <= 1'b0;
         cmp_seen_reg   <= 1'b0;
         tmr_start_reg  <= 1'b0;
         tmr_load_reg   <= '0;
         ev_done_reg    <= 1'b0;
         ev_err_reg     <= 1'b0;
         prom_addr_o    <= '0;
         prom_data_o    <= '0;
         prom_data_oe_o <= 1'b0;
         prom_read_n_o  <= 1'b1;
         prom_prog_o    <= 1'b0;
         ram_addr_o     <= '0;
         ram_wdata_o    <= '0;
         ram_we_o       <= 1'b0;
      end else begin
         tmr_start_reg <= 1'b0;
         ev_done_reg   <= 1'b0;
         ev_err_reg    <= 1'b0;
         ram_we_o      <= 1'b0;
         case (state_reg)
            prom_seq_pkg::S_IDLE: begin
               addr_reg  <= '0;
               phase_reg <= prom_seq_pkg::P_ADDR;
               // presses outside idle never reach this branch
               if (blank_press) begin
                  state_reg  <= prom_seq_pkg::S_BLANK;
                  wr_seq_reg <= 1'b0;
               end else if (wr_press || cmp_press) begin
                  // wait a short window so a two-button chord is not split
                  state_reg     <= prom_seq_pkg::S_CHORD;
                  wr_seen_reg   <= wr_press;
                  cmp_seen_reg  <= cmp_press;
                  tmr_load_reg  <= CHORD_CYC;
                  tmr_start_reg <= 1'b1;
               end
            end
            prom_seq_pkg::S_CHORD: begin
               wr_seen_reg  <= wr_seen_reg | wr_lvl;
               cmp_seen_reg <= cmp_seen_reg | cmp_lvl;
               if (tmr_done) begin
                  if (wr_seen_reg && cmp_seen_reg) begin
                     state_reg <= prom_seq_pkg::S_COPY;
                  end else if (wr_seen_reg) begin
                     state_reg  <= prom_seq_pkg::S_BLANK;
                     wr_seq_reg <= 1'b1;
                  end else begin
                     state_reg  <= prom_seq_pkg::S_CMP;
                     wr_seq_reg <= 1'b0;
                  end
               end
            end
            prom_seq_pkg::S_BLANK,
            prom_seq_pkg::S_PROG,
            prom_seq_pkg::S_COPY,
            prom_seq_pkg::S_CMP: begin
               case (phase_reg)
                  prom_seq_pkg::P_ADDR: begin
                     prom_addr_o   <= addr_reg;
                     ram_addr_o    <= addr_reg;
                     prom_read_n_o <= (state_reg == prom_seq_pkg::S_PROG);
                     tmr_load_reg  <= prom_seq_pkg::TMR_W'(prom_seq_pkg::ACCESS_CYC);
                     tmr_start_reg <= 1'b1;
                     phase_reg     <= prom_seq_pkg::P_WAIT;
                  end
                  prom_seq_pkg::P_WAIT: begin
                     if (tmr_done) begin
                        if (state_reg == prom_seq_pkg::S_PROG) begin
                           prom_data_o    <= ram_rdata_i;
                           prom_data_oe_o <= 1'b1;
                           prom_prog_o    <= 1'b1;
                           tmr_load_reg   <= PULSE_CYC;
                           tmr_start_reg  <= 1'b1;
                           phase_reg      <= prom_seq_pkg::P_PULSE;
                        end else if (state_reg == prom_seq_pkg::S_COPY) begin
                           ram_wdata_o <= prom_data_i;
                           ram_we_o    <= 1'b1;
                           phase_reg   <= prom_seq_pkg::P_PULSE;
                        end else if (scan_mismatch) begin
                           // failure holds its own lamp and raises the error lamp
                           state_reg     <= prom_seq_pkg::S_ERR;
                           err_blank_reg <= (state_reg == prom_seq_pkg::S_BLANK);
                           fail_reg      <= addr_reg;
                           ev_err_reg    <= 1'b1;
                           prom_read_n_o <= 1'b1;
                        end else begin
                           phase_reg <= prom_seq_pkg::P_PULSE;
                        end
                     end
                  end
                  prom_seq_pkg::P_PULSE: begin
                     // programming waits out its pulse, other steps pass at once
                     if (tmr_done || state_reg != prom_seq_pkg::S_PROG) begin
                        prom_prog_o    <= 1'b0;
                        prom_data_oe_o <= 1'b0;
                        phase_reg      <= prom_seq_pkg::P_ADDR;
                        addr_reg       <= scan_last ? '0 : addr_reg + 15'h1;
                        if (scan_last) begin
                           prom_read_n_o <= 1'b1;
                           case (state_reg)
                              prom_seq_pkg::S_BLANK: begin
                                 state_reg   <= wr_seq_reg ? prom_seq_pkg::S_PROG
                                                           : prom_seq_pkg::S_IDLE;
                                 ev_done_reg <= ~wr_seq_reg;
                              end
                              prom_seq_pkg::S_PROG: begin
                                 state_reg <= prom_seq_pkg::S_CMP;
                              end
                              prom_seq_pkg::S_COPY: begin
                                 state_reg <= prom_seq_pkg::S_CMP;
                              end
                              default: begin
                                 state_reg   <= prom_seq_pkg::S_IDLE;
                                 ev_done_reg <= 1'b1;
                              end
                           endcase
                        end
                     end
                  end
                  default: begin
                     phase_reg <= prom_seq_pkg::P_ADDR;
                  end
               endcase
            end
            prom_seq_pkg::S_ERR: begin
               if (err_press) begin
                  state_reg     <= prom_seq_pkg::S_IDLE;
                  err_blank_reg <= 1'b0;
               end
            end
            default: begin
               state_reg <= prom_seq_pkg::S_IDLE;
            end
         endcase
      end
   end

   // lamps follow the step; a failure keeps the lamp of the failing step
   always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         blank_lamp_o          <= 1'b0;
         write_lamp_o          <= 1'b0;
         compare_button_lamp_o <= 1'b0;
         error_lamp_o          <= 1'b0;
         cpu_fault_lamp_o      <= 1'b0;
         power_lamp_o          <= 1'b0;
      end else begin
         blank_lamp_o          <= (state_reg == prom_seq_pkg::S_BLANK)
                                  || (state_reg == prom_seq_pkg::S_ERR && err_blank_reg);
         write_lamp_o          <= (state_reg == prom_seq_pkg::S_PROG)
                                  || (state_reg == prom_seq_pkg::S_COPY)
                                  || (state_reg == prom_seq_pkg::S_CHORD && wr_seen_reg);
         compare_button_lamp_o <= (state_reg == prom_seq_pkg::S_CMP)
                                  || (state_reg == prom_seq_pkg::S_COPY)
                                  || (state_reg == prom_seq_pkg::S_CHORD && cmp_seen_reg)
                                  || (state_reg == prom_seq_pkg::S_ERR && !err_blank_reg);
         error_lamp_o          <= (state_reg == prom_seq_pkg::S_ERR);
         cpu_fault_lamp_o      <= cpu_fault_i;
         power_lamp_o          <= supply_ok_i;
      end
   end

   // interrupt events: done, error, and a fault or supply loss appearing
   assign ev_vec  = {fault_seen_reg == 1'b0 && (cpu_fault_i || !supply_ok_i), ev_err_reg, ev_done_reg};
   assign apb_wr  = psel_i & penable_i & pwrite_i & pready_o;
   assign int_clr = (apb_wr && paddr_i == prom_seq_pkg::OFS_INT_CLR) ? pwdata_i[prom_seq_pkg::NUM_EV-1:0] : '0;

   always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         int_stat_reg   <= '0;
         fault_seen_reg <= 1'b0;
         irq_o          <= 1'b0;
      end else begin
         // a new event wins over a clear in the same cycle
         int_stat_reg   <= (int_stat_reg & ~int_clr) | ev_vec;
         fault_seen_reg <= cpu_fault_i | ~supply_ok_i;
         irq_o          <= |(int_stat_reg & int_en_reg);
      end
   end

   // read mux, sampled in the setup cycle so read data comes from a flop
   always_comb begin
      rd_data = '0;
      rd_hit  = 1'b1;
      case (paddr_i)
         prom_seq_pkg::OFS_LAST:     rd_data[prom_seq_pkg::ADDR_W-1:0] = last_reg;
         prom_seq_pkg::OFS_STATUS: begin
            rd_data[prom_seq_pkg::ST_STATE_LSB +: 3] = state_reg;
            rd_data[prom_seq_pkg::ST_BUSY]  = (state_reg != prom_seq_pkg::S_IDLE);
            rd_data[prom_seq_pkg::ST_BLANK] = blank_lamp_o;
            rd_data[prom_seq_pkg::ST_WRITE] = write_lamp_o;
            rd_data[prom_seq_pkg::ST_CMP]   = compare_button_lamp_o;
            rd_data[prom_seq_pkg::ST_ERR]   = error_lamp_o;
            rd_data[prom_seq_pkg::ST_CPU]   = cpu_fault_lamp_o;
            rd_data[prom_seq_pkg::ST_POWER] = power_lamp_o;
         end
         prom_seq_pkg::OFS_INT_STAT: rd_data[prom_seq_pkg::NUM_EV-1:0] = int_stat_reg;
         prom_seq_pkg::OFS_INT_EN:   rd_data[prom_seq_pkg::NUM_EV-1:0] = int_en_reg;
         prom_seq_pkg::OFS_INT_CLR:  rd_data = '0;
         prom_seq_pkg::OFS_FAIL:     rd_data[prom_seq_pkg::ADDR_W-1:0] = fail_reg;
         default:                    rd_hit  = 1'b0;
      endcase
   end

   // zero-wait slave: pready rises for the first access cycle
   always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         prdata_o   <= '0;
         pready_o   <= 1'b0;
         pslverr_o  <= 1'b0;
         last_reg   <= prom_seq_pkg::LAST_RST;
         int_en_reg <= prom_seq_pkg::INT_EN_RST;
      end else begin
         pready_o  <= psel_i & ~penable_i;
         pslverr_o <= psel_i & ~penable_i & ~rd_hit;
         prdata_o  <= (psel_i && !penable_i && !pwrite_i) ? rd_data : '0;
         // changing the range mid-pass would skip or overrun addresses
         if (apb_wr && paddr_i == prom_seq_pkg::OFS_LAST && state_reg == prom_seq_pkg::S_IDLE) begin
            last_reg <= pwdata_i[prom_seq_pkg::ADDR_W-1:0];
         end
         if (apb_wr && paddr_i == prom_seq_pkg::OFS_INT_EN) begin
            int_en_reg <= pwdata_i[prom_seq_pkg::NUM_EV-1:0];
         end
      end
   end

endmodule

// ---- verilog/prom_seq_pkg.sv ----
/*
   Constants and types for the PROM programming sequencer: register map,
   field layout, reset values, timing counts and state encodings.
   Assumes a 20 MHz system clock and an 8-bit PROM of up to 32K bytes.
*/
package prom_seq_pkg;

   // clock and array geometry
   localparam int CLK_HZ      = 20_000_000;
   localparam int CLK_MHZ     = CLK_HZ / 1_000_000;
   localparam int ADDR_W      = 15;
   localparam int DATA_W      = 8;
   localparam int TMR_W       = 20;
   localparam int APB_AW      = 12;

   // an erased cell reads all ones
   localparam logic [DATA_W-1:0] BLANK_VALUE = 8'hFF;

   // timing: least access time rounds up, others are counts of whole cycles
   localparam int ACCESS_NS     = 250;
   localparam int ACCESS_CYC    = (ACCESS_NS * CLK_MHZ + 999) / 1000;
   localparam int PULSE_US      = 1000;
   localparam int PULSE_CYC_DEF = PULSE_US * CLK_MHZ;
   localparam int CHORD_MS      = 20;
   localparam int CHORD_CYC_DEF = CHORD_MS * 1000 * CLK_MHZ;

   // register byte offsets
   localparam logic [APB_AW-1:0] OFS_LAST     = 12'h000;
   localparam logic [APB_AW-1:0] OFS_STATUS   = 12'h004;
   localparam logic [APB_AW-1:0] OFS_INT_STAT = 12'h008;
   localparam logic [APB_AW-1:0] OFS_INT_EN   = 12'h00C;
   localparam logic [APB_AW-1:0] OFS_INT_CLR  = 12'h010;
   localparam logic [APB_AW-1:0] OFS_FAIL     = 12'h014;

   // reset values
   localparam logic [ADDR_W-1:0] LAST_RST   = 15'h7FFF;
   localparam logic [2:0]        INT_EN_RST = 3'h0;

   // interrupt event bits
   localparam int EV_DONE  = 0;
   localparam int EV_ERR   = 1;
   localparam int EV_FAULT = 2;
   localparam int NUM_EV   = 3;

   // status register fields
   localparam int ST_STATE_LSB = 0;
   localparam int ST_BUSY      = 3;
   localparam int ST_BLANK     = 4;
   localparam int ST_WRITE     = 5;
   localparam int ST_CMP       = 6;
   localparam int ST_ERR       = 7;
   localparam int ST_CPU       = 8;
   localparam int ST_POWER     = 9;

   // gray along idle, chord, blank, program, compare
   typedef enum logic [2:0] {
      S_IDLE  = 3'h0,
      S_CHORD = 3'h1,
      S_BLANK = 3'h3,
      S_PROG  = 3'h2,
      S_CMP   = 3'h6,
      S_COPY  = 3'h7,
      S_ERR   = 3'h5
   } state_t;

   typedef enum logic [1:0] {
      P_ADDR  = 2'h0,
      P_WAIT  = 2'h1,
      P_PULSE = 2'h3
   } phase_t;

endpackage

// ---- verilog/press_detect.sv ----
/*
   Pushbutton press detector: registered level and a one-cycle press pulse.
   Assumes the button input is already clean and synchronous to clk_sys_i.
*/
`timescale 1ns/100ps
module press_detect (
   input  wire logic clk_sys_i,
   input  wire logic arst_n_i,
   input  wire logic btn_i,
   output logic      level_o,
   output logic      press_o
);

   always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         level_o <= 1'b0;
         press_o <= 1'b0;
      end else begin
         level_o <= btn_i;
         press_o <= btn_i & ~level_o;
      end
   end

endmodule

// ---- verilog/step_timer.sv ----
/*
   Down-counting one-shot timer: start loads a count, done pulses one cycle
   after the count has run out. Assumes a load value of at least one.
*/
`timescale 1ns/100ps
module step_timer #(
   parameter int W = 20
) (
   input  wire logic         clk_sys_i,
   input  wire logic         arst_n_i,
   input  wire logic         start_i,
   input  wire logic [W-1:0] load_i,
   output logic              done_o
);

   logic [W-1:0] cnt_reg;
   logic         busy_reg;

   always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         cnt_reg  <= '0;
         busy_reg <= 1'b0;
         done_o   <= 1'b0;
      end else if (start_i) begin
         cnt_reg  <= load_i;
         busy_reg <= 1'b1;
         done_o   <= 1'b0;
      end else if (busy_reg && cnt_reg <= W'(1)) begin
         busy_reg <= 1'b0;
         done_o   <= 1'b1;
      end else begin
         cnt_reg  <= busy_reg ? cnt_reg - W'(1) : cnt_reg;
         done_o   <= 1'b0;
      end
   end

endmodule

// ---- tb/prom_side_model.sv ----
/* Socketed PROM and user RAM model, sixteen bytes each.
   Assumes the bench keeps the last address below sixteen. */
`timescale 1ns/100ps
module prom_side_model (
   input  wire logic        clk_sys_i,
   input  wire logic [14:0] prom_addr_i,
   input  wire logic        prom_read_n_i,
   input  wire logic [7:0]  prom_wdata_i,
   input  wire logic        prom_prog_i,
   input  wire logic [14:0] ram_addr_i,
   input  wire logic [7:0]  ram_wdata_i,
   input  wire logic        ram_we_i,
   output logic      [7:0]  prom_rdata_o,
   output logic      [7:0]  ram_rdata_o
);
   logic [7:0] prom [16];
   logic [7:0] ram  [16];
   // released outputs show the inverse, so a stale byte never matches
   assign prom_rdata_o = prom_read_n_i ? ~prom[prom_addr_i[3:0]] : prom[prom_addr_i[3:0]];
   assign ram_rdata_o  = ram[ram_addr_i[3:0]];
   always @(posedge clk_sys_i) begin
      if (prom_prog_i)
         prom[prom_addr_i[3:0]] <= prom[prom_addr_i[3:0]] & prom_wdata_i;
      if (ram_we_i)
         ram[ram_addr_i[3:0]] <= ram_wdata_i;
   end
endmodule

// ---- tb/prom_seq_properties.sv ----
/* Lamp and strobe properties of the sequencer.
   Assumes registered lamps and buttons held two cycles. */
`timescale 1ns/100ps
module prom_seq_properties (
   input wire logic clk_sys_i,
   input wire logic arst_n_i,
   input wire logic error_button_i,
   input wire logic cpu_fault_i,
   input wire logic supply_ok_i,
   input wire logic blank_lamp_o,
   input wire logic write_lamp_o,
   input wire logic compare_button_lamp_o,
   input wire logic error_lamp_o,
   input wire logic cpu_fault_lamp_o,
   input wire logic power_lamp_o,
   input wire logic prom_prog_o,
   input wire logic prom_data_oe_o,
   input wire logic ram_we_o
);
   default clocking @(posedge clk_sys_i);
   endclocking
   default disable iff (!arst_n_i);
   sequence s_prog_end;
      write_lamp_o && !compare_button_lamp_o ##1 !write_lamp_o;
   endsequence
   a_fault_lamp: assert property (1 |=> cpu_fault_lamp_o == $past(cpu_fault_i))
      else $error("fault lamp not following input");
   a_power_lamp: assert property ($changed(supply_ok_i) |=> power_lamp_o == $past(supply_ok_i))
      else $error("power lamp not following supply");
   a_err_pair: assert property (error_lamp_o |-> blank_lamp_o != compare_button_lamp_o && !write_lamp_o)
      else $error("error lamp without one step lamp");
   a_err_clear: assert property ($rose(error_button_i) && error_lamp_o |-> ##[1:4] !error_lamp_o && !compare_button_lamp_o)
      else $error("error press did not clear");
   a_err_hold: assert property ($fell(error_lamp_o) |-> $past(error_button_i) || $past(error_button_i, 2))
      else $error("error lamp dropped without press");
   a_prog_gate: assert property (prom_prog_o |-> prom_data_oe_o && write_lamp_o && !blank_lamp_o)
      else $error("program pulse outside write step");
   a_blank_quiet: assert property (blank_lamp_o |-> !prom_prog_o && !prom_data_oe_o && !ram_we_o)
      else $error("write activity during blank check");
   a_copy_we: assert property (ram_we_o |-> compare_button_lamp_o && !error_lamp_o)
      else $error("ram write outside transfer");
   a_step_order: assert property (s_prog_end |-> compare_button_lamp_o || blank_lamp_o)
      else $error("verify did not follow programming");
endmodule
bind prom_program_sequencer prom_seq_properties u_props (.*);

// ---- tb/testbench.sv ----
/* Bench for the PROM sequencer: APB tasks, button presses, lamp checks.
   Assumes short pulse and chord counts and a four-byte image. */
`timescale 1ns/100ps
module testbench;
   logic        clk_sys_i = 0, arst_n_i = 0, psel = 0, pen = 0, power_lamp = 0, flt = 0, sok = 1, irq, pready, perr, pe;
   logic [11:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata, rd;
   logic [3:0]  btn = 0, lamps;
   logic [1:0]  sys;
   logic        oe, rdn, prog, we;
   logic [14:0] pa, ra;
   logic [7:0]  pdi, pdo, rdi, rdo;
   int          fail_count = 0, total_checks = 0, cyc = 0;
   always #25 clk_sys_i = ~clk_sys_i;
   prom_program_sequencer #(.PULSE_CYC(20'h3), .CHORD_CYC(20'h4)) DUT (.clk_sys_i, .arst_n_i, .psel_i(psel),
      .penable_i(pen), .pwrite_i(power_lamp), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
      .pslverr_o(pe), .irq_o(irq), .blank_button_i(btn[3]), .write_button_i(btn[2]), .compare_button_i(btn[1]),
      .error_button_i(btn[0]), .cpu_fault_i(flt), .supply_ok_i(sok), .blank_lamp_o(lamps[3]),
      .write_lamp_o(lamps[2]), .compare_button_lamp_o(lamps[1]), .error_lamp_o(lamps[0]), .cpu_fault_lamp_o(sys[1]),
      .power_lamp_o(sys[0]), .prom_addr_o(pa), .prom_data_i(pdi), .prom_data_o(pdo), .prom_data_oe_o(oe),
      .prom_read_n_o(rdn), .prom_prog_o(prog), .ram_addr_o(ra), .ram_rdata_i(rdi), .ram_wdata_o(rdo), .ram_we_o(we));
   prom_side_model mem (.clk_sys_i, .prom_addr_i(pa), .prom_read_n_i(rdn), .prom_wdata_i(pdo), .prom_prog_i(prog),
      .ram_addr_i(ra), .ram_wdata_i(rdo), .ram_we_i(we), .prom_rdata_o(pdi), .ram_rdata_o(rdi));
   task automatic final_report();
      if (fail_count == 0 && total_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      total_checks++;
      if (g !== e) begin
         fail_count++;
         $display("[FAIL] %s expected %h seen %h", n, e, g);
      end
   endtask
   // request held until pready is seen; no cycle count assumed
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel <= 1;
      power_lamp <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys_i);
      pen <= 1;
      do @(posedge clk_sys_i); while (pready !== 1'b1);
      rd = prdata;
      perr = pe;
      psel <= 0;
      pen <= 0;
      @(posedge clk_sys_i);
   endtask
   task automatic press(input logic [3:0] b);
      btn <= b;
      repeat (2) @(posedge clk_sys_i);
      btn <= 0;
      repeat (3) @(posedge clk_sys_i);
   endtask
   task automatic op(input logic [3:0] b, input logic [31:0] ist, input logic [3:0] el);
      press(b);
      while (irq !== 1'b1) @(posedge clk_sys_i);
      repeat (2) @(posedge clk_sys_i);
      chk("lamps", el, lamps);
      apb(0, 12'h008, 0);
      chk("int_stat", ist, rd);
      apb(1, 12'h010, 32'h7);
      @(posedge clk_sys_i);
      chk("irq", 0, irq);
   endtask
   always @(posedge clk_sys_i) begin
      cyc++;
      if (cyc > 20000) begin
         fail_count++;
         final_report();
      end
   end
   initial begin
      for (int i = 0; i < 4; i++) begin
         mem.prom[i] = 8'hFF;
         mem.ram[i] = 8'(i * 37 + 1);
      end
      repeat (4) @(posedge clk_sys_i);
      arst_n_i <= 1;
      @(posedge clk_sys_i);
      apb(0, 12'h004, 0);
      chk("status", 32'h200, rd);
      apb(1, 12'h000, 32'h3);
      apb(1, 12'h00C, 32'h3);
      apb(0, 12'h0FC, 0);
      chk("unmapped", 1, perr);
      op(4'h8, 1, 0);
      op(4'h4, 1, 0);
      for (int i = 0; i < 4; i++)
         chk("prom", 8'(i * 37 + 1), mem.prom[i]);
      op(4'h8, 2, 4'h9);
      press(4'h8);
      chk("busy_press", 4'h9, lamps);
      press(4'h1);
      chk("cleared", 0, lamps);
      mem.ram[1] = 8'h00;
      op(4'h2, 2, 4'h3);
      press(4'h1);
      chk("cleared", 0, lamps);
      for (int i = 0; i < 4; i++)
         mem.ram[i] = 8'h00;
      op(4'h6, 1, 0);
      for (int i = 0; i < 4; i++)
         chk("ram", 8'(i * 37 + 1), mem.ram[i]);
      flt <= 1;
      sok <= 0;
      repeat (2) @(posedge clk_sys_i);
      chk("sys_lamps", 2'h2, sys);
      final_report();
   end
endmodule
